/* common/prf_pkg.sv */
package prf_pkg;

   // Operand sizes seen by the general register write port
   typedef enum logic [2:0] {
      PRF_SZ_BIT,
      PRF_SZ_BYTE,
      PRF_SZ_WORD,
      PRF_SZ_LONG,
      PRF_SZ_QUAD
   } prf_size_t;

   localparam int          PRF_XLEN      = 32;
   localparam int          PRF_NUM_PHYS  = 17;   // D0-D7, A0-A6, user and supervisor stack
   localparam logic [4:0]  PRF_PHYS_USP  = 5'h0F;
   localparam logic [4:0]  PRF_PHYS_SSP  = 5'h10;
   localparam logic [3:0]  PRF_SEL_SP    = 4'hF;
   localparam int          PRF_ADDR_BASE = 8;

   // State word layout
   localparam int          PRF_SR_T      = 15;
   localparam int          PRF_SR_S      = 13;
   localparam int          PRF_SR_MLO    = 8;
   localparam int          PRF_SR_MHI    = 10;
   localparam int          PRF_CCR_HI    = 4;
   localparam logic [15:0] PRF_SR_IMPL   = 16'hA71F;
   localparam logic [15:0] PRF_SR_RESET  = 16'h2700;
   localparam logic [2:0]  PRF_IRQ_NMI   = 3'h7;

   // Function codes of memory accesses
   localparam logic [2:0]  PRF_FC_UDATA  = 3'h1;
   localparam logic [2:0]  PRF_FC_UPROG  = 3'h2;
   localparam logic [2:0]  PRF_FC_SDATA  = 3'h5;
   localparam logic [2:0]  PRF_FC_SPROG  = 3'h6;

   // Control register map on the register port
   localparam logic [7:0]  PRF_REG_SR    = 8'h00;
   localparam logic [7:0]  PRF_REG_CCR   = 8'h04;
   localparam logic [7:0]  PRF_REG_PC    = 8'h08;
   localparam logic [7:0]  PRF_REG_VBR   = 8'h0C;
   localparam logic [7:0]  PRF_REG_SFC   = 8'h10;
   localparam logic [7:0]  PRF_REG_DFC   = 8'h14;
   localparam logic [7:0]  PRF_REG_USP   = 8'h18;
   localparam logic [7:0]  PRF_REG_SSP   = 8'h1C;

   localparam logic [31:0] PRF_PC_RESET  = 32'h0000_0000;
   localparam logic [31:0] PRF_VBR_RESET = 32'h0000_0000;

endpackage : prf_pkg

/* rtl/prf_top.sv */
`timescale 1ns/100ps
module prf_top
   import prf_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   output logic                   reg_denied,
   input  wire logic              gpr_we,
   input  wire logic [3:0]        gpr_wsel,
   input  wire prf_size_t         gpr_wsize,
   input  wire logic [4:0]        gpr_wbit,
   input  wire logic [63:0]       gpr_wdata,
   input  wire logic [3:0]        rd_a_sel,
   output logic      [31:0]       rd_a_data,
   input  wire logic [3:0]        rd_b_sel,
   output logic      [31:0]       rd_b_data,
   input  wire logic [3:0]        idx_sel,
   input  wire logic              idx_long,
   output logic      [31:0]       idx_value,
   input  wire logic              ccr_we,
   input  wire logic [4:0]        ccr_in,
   output logic      [15:0]       sr_out,
   output logic                   trace_on,
   output logic                   super_mode,
   input  wire logic              pc_inc,
   input  wire logic [3:0]        pc_step,
   input  wire logic              pc_load,
   input  wire logic [31:0]       pc_new,
   output logic      [31:0]       pc_out,
   input  wire logic              exc_enter,
   input  wire logic              exc_irq,
   input  wire logic [7:0]        vec_num,
   output logic      [31:0]       vec_addr,
   input  wire logic [2:0]        irq_level,
   output logic                   irq_ack,
   input  wire logic              acc_req,
   input  wire logic              acc_prog,
   input  wire logic              acc_alt_src,
   input  wire logic              acc_alt_dst,
   input  wire logic [31:0]       acc_addr,
   output logic                   mem_valid,
   output logic      [2:0]        mem_fc,
   output logic      [31:0]       mem_addr
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic [31:0] gpr_q [PRF_NUM_PHYS];
   logic [15:0] sr_q;
   logic [15:0] sr_d;
   logic [31:0] pc_q;
   logic [31:0] pc_d;
   logic [31:0] vbr_q;
   logic [2:0]  sfc_q;
   logic [2:0]  dfc_q;

   wire         sup = sr_q[PRF_SR_S];
   wire [2:0]   irq_mask = sr_q[PRF_SR_MHI:PRF_SR_MLO];

   // Map a visible register number onto storage, A7 by privilege
   function automatic logic [4:0] prf_phys(input logic [3:0] sel, input logic s);
      prf_phys = (sel == PRF_SEL_SP) ? (s ? PRF_PHYS_SSP : PRF_PHYS_USP) : {1'b0, sel};
   endfunction : prf_phys

   // Merge new data into a register by operand size
   function automatic logic [31:0] prf_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input prf_size_t   sz,
                                             input logic [4:0]  bn,
                                             input logic        is_addr);
      logic [31:0] r;
      r = nw;
      case (sz)
         PRF_SZ_BIT: begin
            r = old;
            r[bn] = nw[0];
         end
         PRF_SZ_BYTE: r = {old[31:8], nw[7:0]};
         PRF_SZ_WORD: r = is_addr ? {{16{nw[15]}}, nw[15:0]} : {old[31:16], nw[15:0]};
         default:     r = nw;
      endcase
      prf_merge = r;
   endfunction : prf_merge

   ////////////////////////////////////////////////////////////////////////////
   // Register port decode

   wire        bus_ok    = sup || (reg_addr == PRF_REG_CCR);
   wire        bus_wr    = reg_wr && bus_ok;
   wire        bus_den   = (reg_wr || reg_rd) && !bus_ok;
   wire        wr_sr     = bus_wr && (reg_addr == PRF_REG_SR);
   wire        wr_ccr    = bus_wr && (reg_addr == PRF_REG_CCR);
   wire        wr_pc     = bus_wr && (reg_addr == PRF_REG_PC);
   wire        wr_vbr    = bus_wr && (reg_addr == PRF_REG_VBR);
   wire        wr_sfc    = bus_wr && (reg_addr == PRF_REG_SFC);
   wire        wr_dfc    = bus_wr && (reg_addr == PRF_REG_DFC);
   wire        wr_usp    = bus_wr && (reg_addr == PRF_REG_USP);
   wire        wr_ssp    = bus_wr && (reg_addr == PRF_REG_SSP);

   // Read mux, unmapped and denied reads give zero
   wire [31:0] bus_mux =
      (reg_addr == PRF_REG_SR)  ? {16'h0000, sr_q} :
      (reg_addr == PRF_REG_CCR) ? {24'h000000, sr_q[7:0]} :
      (reg_addr == PRF_REG_PC)  ? pc_q :
      (reg_addr == PRF_REG_VBR) ? vbr_q :
      (reg_addr == PRF_REG_SFC) ? {29'h0, sfc_q} :
      (reg_addr == PRF_REG_DFC) ? {29'h0, dfc_q} :
      (reg_addr == PRF_REG_USP) ? gpr_q[PRF_PHYS_USP] :
      (reg_addr == PRF_REG_SSP) ? gpr_q[PRF_PHYS_SSP] : 32'h0000_0000;
   wire [31:0] bus_rd_d = (reg_rd && bus_ok) ? bus_mux : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // General registers

   wire [4:0]  wphys   = prf_phys(gpr_wsel, sup);
   wire        w_addr  = gpr_wsel[3];
   wire        w_quad  = (gpr_wsize == PRF_SZ_QUAD);
   wire        w_wl    = (gpr_wsize == PRF_SZ_WORD) || (gpr_wsize == PRF_SZ_LONG);
   wire        w_legal = gpr_we && (!w_addr || w_wl);
   wire [2:0]  w_hi    = gpr_wsel[2:0] + 3'h1;                          // Quad high half partner

   genvar gi;
   generate
      for (gi = 0; gi < PRF_NUM_PHYS; gi++) begin : g_gpr
         wire hit_lo = w_legal && (wphys == 5'(gi));
         wire hit_hi = gpr_we && w_quad && !w_addr && (gi < PRF_ADDR_BASE)
                       && (w_hi == 3'(gi));
         wire hit_bus = (gi == PRF_PHYS_USP) ? wr_usp :
                        (gi == PRF_PHYS_SSP) ? wr_ssp : 1'b0;
         // Core write wins over the register port
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               gpr_q[gi] <= 32'h0000_0000;
            end else if (hit_lo) begin
               gpr_q[gi] <= prf_merge(gpr_q[gi], gpr_wdata[31:0], gpr_wsize, gpr_wbit,
                                      gi >= PRF_ADDR_BASE);
            end else if (hit_hi) begin
               gpr_q[gi] <= gpr_wdata[63:32];
            end else if (hit_bus) begin
               gpr_q[gi] <= reg_wdata;
            end
         end
      end
   endgenerate

   // Read ports and index value
   wire [31:0] rd_a_d  = gpr_q[prf_phys(rd_a_sel, sup)];
   wire [31:0] rd_b_d  = gpr_q[prf_phys(rd_b_sel, sup)];
   wire [31:0] idx_raw = gpr_q[prf_phys(idx_sel, sup)];
   wire [31:0] idx_d   = idx_long ? idx_raw : {{16{idx_raw[15]}}, idx_raw[15:0]};

   ////////////////////////////////////////////////////////////////////////////
   // State word, register port last so software wins

   always_comb begin
      sr_d = sr_q;
      if (ccr_we) begin
         sr_d[PRF_CCR_HI:0] = ccr_in;
      end
      if (exc_enter) begin
         sr_d[PRF_SR_S] = 1'b1;
         sr_d[PRF_SR_T] = 1'b0;
         if (exc_irq) begin
            sr_d[PRF_SR_MHI:PRF_SR_MLO] = irq_level;
         end
      end
      if (wr_sr) begin
         sr_d = reg_wdata[15:0] & PRF_SR_IMPL;
      end else if (wr_ccr) begin
         sr_d[PRF_CCR_HI:0] = reg_wdata[PRF_CCR_HI:0];
      end
   end

   // Program counter, core load beats advance beats the register port
   assign pc_d = pc_load ? pc_new :
                 pc_inc  ? pc_q + {28'h0000000, pc_step} :
                 wr_pc   ? reg_wdata : pc_q;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sr_q  <= PRF_SR_RESET;
         pc_q  <= PRF_PC_RESET;
      end else begin
         sr_q  <= sr_d;
         pc_q  <= pc_d;
      end
   end

   // Table base and space code registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         vbr_q <= PRF_VBR_RESET;
         sfc_q <= 3'h0;
         dfc_q <= 3'h0;
      end else begin
         if (wr_vbr) vbr_q <= reg_wdata;
         if (wr_sfc) sfc_q <= reg_wdata[2:0];
         if (wr_dfc) dfc_q <= reg_wdata[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt gate, vector address, access function code

   wire        irq_d  = (irq_level > irq_mask) || (irq_level == PRF_IRQ_NMI);
   wire [31:0] vec_d  = vbr_q + {22'h000000, vec_num, 2'b00};
   wire [2:0]  fc_std = sup ? (acc_prog ? PRF_FC_SPROG : PRF_FC_SDATA)
                            : (acc_prog ? PRF_FC_UPROG : PRF_FC_UDATA);
   wire [2:0]  fc_d   = acc_alt_src ? sfc_q :
                        acc_alt_dst ? dfc_q : fc_std;

   ////////////////////////////////////////////////////////////////////////////
   // Output registers

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata  <= 32'h0000_0000;
         reg_denied <= 1'b0;
         rd_a_data  <= 32'h0000_0000;
         rd_b_data  <= 32'h0000_0000;
         idx_value  <= 32'h0000_0000;
         irq_ack    <= 1'b0;
         vec_addr   <= 32'h0000_0000;
         mem_valid  <= 1'b0;
         mem_fc     <= 3'h0;
         mem_addr   <= 32'h0000_0000;
      end else begin
         reg_rdata  <= bus_rd_d;
         reg_denied <= bus_den;
         rd_a_data  <= rd_a_d;
         rd_b_data  <= rd_b_d;
         idx_value  <= idx_d;
         irq_ack    <= irq_d;
         vec_addr   <= vec_d;
         mem_valid  <= acc_req;
         if (acc_req) begin
            mem_fc   <= fc_d;
            mem_addr <= acc_addr;
         end
      end
   end

   // State word and counter mirrors, from the next-state values so they match sr_q, pc_q
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sr_out     <= PRF_SR_RESET;
         trace_on   <= PRF_SR_RESET[PRF_SR_T];
         super_mode <= PRF_SR_RESET[PRF_SR_S];
         pc_out     <= PRF_PC_RESET;
      end else begin
         sr_out     <= sr_d;
         trace_on   <= sr_d[PRF_SR_T];
         super_mode <= sr_d[PRF_SR_S];
         pc_out     <= pc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   a_quad_high_half: assert property (
      gpr_we && gpr_wsize == PRF_SZ_QUAD && gpr_wsel == 4'h7
      |=> gpr_q[0] == $past(gpr_wdata[63:32]) && gpr_q[7] == $past(gpr_wdata[31:0]))
      else $error("quad write did not fill both halves");

   a_byte_keeps_upper: assert property (
      gpr_we && gpr_wsize == PRF_SZ_BYTE && gpr_wsel == 4'h3
      |=> gpr_q[3] == {$past(gpr_q[3][31:8]), $past(gpr_wdata[7:0])})
      else $error("byte write disturbed upper bits");

   a_stack_select: assert property (
      gpr_we && gpr_wsel == PRF_SEL_SP && gpr_wsize == PRF_SZ_LONG && !sup
      |=> gpr_q[PRF_PHYS_USP] == $past(gpr_wdata[31:0])
          && $stable(gpr_q[PRF_PHYS_SSP]))
      else $error("user write to A7 missed the user stack");

   a_addr_word_sext: assert property (
      gpr_we && gpr_wsel == 4'h9 && gpr_wsize == PRF_SZ_WORD
      |=> gpr_q[9] == {{16{$past(gpr_wdata[15])}}, $past(gpr_wdata[15:0])})
      else $error("address word write not sign extended");

   a_index_word: assert property (
      !idx_long ##1 1'b1 |-> idx_value[31:16] == {16{idx_value[15]}})
      else $error("word index not sign extended");

   a_pc_advance: assert property (
      pc_inc && !pc_load |=> pc_out == $past(pc_q) + 32'($past(pc_step)))
      else $error("program counter step wrong");

   a_irq_gate: assert property (
      irq_ack |-> $past(irq_level) == PRF_IRQ_NMI || $past(irq_level) > $past(irq_mask))
      else $error("interrupt acknowledged below mask");

   a_user_sr_guard: assert property (
      reg_wr && !sup && reg_addr == PRF_REG_SR && !exc_enter
      |=> $stable(sr_q[PRF_SR_T:PRF_SR_MLO]) && reg_denied)
      else $error("user write reached the state word");

   a_exc_super: assert property (
      exc_enter && !wr_sr |=> super_mode && !trace_on)
      else $error("exception entry left user or trace mode");

   a_vector_addr: assert property (
      ##1 vec_addr == $past(vbr_q) + {22'h000000, $past(vec_num), 2'b00})
      else $error("vector address wrong");

   a_alt_space: assert property (
      acc_req && acc_alt_src |=> mem_valid && mem_fc == $past(sfc_q))
      else $error("alternate source code not used");

   c_quad_write: cover property (gpr_we && gpr_wsize == PRF_SZ_QUAD);
   c_irq_ack:    cover property (irq_ack && irq_level != PRF_IRQ_NMI);
   c_user_deny:  cover property (reg_denied);
   c_user_a7:    cover property (gpr_we && gpr_wsel == PRF_SEL_SP && !sup);
endmodule : prf_top

/* tb/tb_processor_register_file.sv */
`timescale 1ns/100ps
// Compare one value, count it, report a mismatch at once
`define CHK(nm, exp, got) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         errors++; \
         $display("BAD %s expected %h seen %h", nm, exp, got); \
      end \
   end

module tb_processor_register_file
   import prf_pkg::*;
;
   logic        clk_sys;
   logic        rst_b;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd_a_data, rd_b_data, idx_value, pc_new, pc_out;
   logic        reg_wr, reg_rd, reg_denied, gpr_we, idx_long, ccr_we, trace_on, super_mode;
   logic [3:0]  gpr_wsel, rd_a_sel, rd_b_sel, idx_sel, pc_step;
   prf_size_t   gpr_wsize;
   logic [4:0]  gpr_wbit, ccr_in;
   logic [63:0] gpr_wdata;
   logic [15:0] sr_out;
   logic        pc_inc, pc_load, exc_enter, exc_irq, irq_ack, acc_req, acc_prog;
   logic        acc_alt_src, acc_alt_dst, mem_valid;
   logic [7:0]  vec_num;
   logic [31:0] vec_addr, acc_addr, mem_addr;
   logic [2:0]  irq_level, mem_fc;
   int          errors, num_checks, cycles;

   prf_top prf_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_denied(reg_denied), .gpr_we(gpr_we), .gpr_wsel(gpr_wsel), .gpr_wsize(gpr_wsize),
      .gpr_wbit(gpr_wbit), .gpr_wdata(gpr_wdata), .rd_a_sel(rd_a_sel), .rd_a_data(rd_a_data),
      .rd_b_sel(rd_b_sel), .rd_b_data(rd_b_data), .idx_sel(idx_sel), .idx_long(idx_long),
      .idx_value(idx_value), .ccr_we(ccr_we), .ccr_in(ccr_in), .sr_out(sr_out),
      .trace_on(trace_on), .super_mode(super_mode), .pc_inc(pc_inc), .pc_step(pc_step),
      .pc_load(pc_load), .pc_new(pc_new), .pc_out(pc_out), .exc_enter(exc_enter),
      .exc_irq(exc_irq), .vec_num(vec_num), .vec_addr(vec_addr), .irq_level(irq_level),
      .irq_ack(irq_ack), .acc_req(acc_req), .acc_prog(acc_prog), .acc_alt_src(acc_alt_src),
      .acc_alt_dst(acc_alt_dst), .acc_addr(acc_addr), .mem_valid(mem_valid),
      .mem_fc(mem_fc), .mem_addr(mem_addr));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   always #5 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles >= 3000) begin
         errors++;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register port and core-side access tasks
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input logic den);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1;
      `CHK("reg_rdata", exp, reg_rdata)
      `CHK("reg_denied", den, reg_denied)
   endtask : reg_read

   task automatic gpr_write(input logic [3:0] s, input prf_size_t z, input logic [4:0] b,
                            input logic [63:0] d);
      @(posedge clk_sys);
      gpr_we    <= 1'b1;
      gpr_wsel  <= s;
      gpr_wsize <= z;
      gpr_wbit  <= b;
      gpr_wdata <= d;
      @(posedge clk_sys);
      gpr_we    <= 1'b0;
   endtask : gpr_write

   task automatic gpr_read(input logic [3:0] s, input logic [31:0] exp);
      @(posedge clk_sys);
      rd_a_sel <= s;
      rd_b_sel <= s;
      @(posedge clk_sys);
      #1;
      `CHK("rd_a_data", exp, rd_a_data)
      `CHK("rd_b_data", exp, rd_b_data)
   endtask : gpr_read

   task automatic idx_read(input logic [3:0] s, input logic lng, input logic [31:0] exp);
      @(posedge clk_sys);
      idx_sel  <= s;
      idx_long <= lng;
      @(posedge clk_sys);
      #1;
      `CHK("idx_value", exp, idx_value)
   endtask : idx_read

   task automatic irq_chk(input logic [2:0] lvl, input logic exp);
      @(posedge clk_sys);
      irq_level <= lvl;
      @(posedge clk_sys);
      #1;
      `CHK("irq_ack", exp, irq_ack)
   endtask : irq_chk

   task automatic acc(input logic p, input logic s, input logic d, input logic [2:0] fc);
      @(posedge clk_sys);
      acc_req     <= 1'b1;
      acc_prog    <= p;
      acc_alt_src <= s;
      acc_alt_dst <= d;
      acc_addr    <= 32'h0010_0000 + 32'(fc);
      @(posedge clk_sys);
      acc_req     <= 1'b0;
      #1;
      `CHK("mem_valid", 1'b1, mem_valid)
      `CHK("mem_fc", fc, mem_fc)
      `CHK("mem_addr", 32'h0010_0000 + 32'(fc), mem_addr)
   endtask : acc

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {clk_sys, rst_b, reg_addr, reg_wdata, reg_wr, reg_rd, gpr_we, gpr_wsel} = '0;
      {gpr_wbit, gpr_wdata, rd_a_sel, rd_b_sel, idx_sel, idx_long, ccr_we, ccr_in} = '0;
      {pc_inc, pc_step, pc_load, pc_new, exc_enter, exc_irq, vec_num, irq_level} = '0;
      {acc_req, acc_prog, acc_alt_src, acc_alt_dst, acc_addr} = '0;
      gpr_wsize = PRF_SZ_LONG;
      errors = 0;
      num_checks = 0;
      cycles = 0;
      repeat (10) @(posedge clk_sys);
      #1;
      `CHK("sr_out", 16'h2700, sr_out)
      `CHK("super_mode", 1'b1, super_mode)
      `CHK("pc_out", 32'h0, pc_out)
      rst_b <= 1'b1;
      // Whole state word, trace bit and mask threshold
      reg_write(PRF_REG_SR, 32'hFFFF_FFFF);
      reg_read(PRF_REG_SR, 32'h0000_A71F, 1'b0);
      `CHK("trace_on", 1'b1, trace_on)
      irq_chk(3'h6, 1'b0);
      irq_chk(3'h7, 1'b1);
      reg_write(PRF_REG_SR, 32'h0000_2300);
      irq_chk(3'h3, 1'b0);
      irq_chk(3'h4, 1'b1);
      // Condition codes follow the last operation
      @(posedge clk_sys);
      ccr_we <= 1'b1;
      ccr_in <= 5'h15;
      @(posedge clk_sys);
      ccr_we <= 1'b0;
      #1;
      `CHK("sr_out", 16'h2315, sr_out)
      reg_read(PRF_REG_CCR, 32'h0000_0015, 1'b0);
      // Vector table base plus displacement, top vector
      reg_write(PRF_REG_VBR, 32'h0000_1000);
      reg_read(PRF_REG_VBR, 32'h0000_1000, 1'b0);
      vec_num <= 8'hFF;
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK("vec_addr", 32'h0000_13FC, vec_addr)
      // Space codes and access function codes
      reg_write(PRF_REG_SFC, 32'hFFFF_FFFF);
      reg_write(PRF_REG_DFC, 32'h0000_0002);
      reg_read(PRF_REG_SFC, 32'h0000_0007, 1'b0);
      reg_read(PRF_REG_DFC, 32'h0000_0002, 1'b0);
      acc(1'b0, 1'b1, 1'b0, 3'h7);
      acc(1'b0, 1'b0, 1'b1, 3'h2);
      acc(1'b1, 1'b1, 1'b1, 3'h7);
      acc(1'b0, 1'b0, 1'b0, PRF_FC_SDATA);
      acc(1'b1, 1'b0, 1'b0, PRF_FC_SPROG);
      reg_read(8'h20, 32'h0, 1'b0);
      // Program counter: load beats advance, then advance
      @(posedge clk_sys);
      pc_load <= 1'b1;
      pc_new  <= 32'h0000_0400;
      pc_inc  <= 1'b1;
      pc_step <= 4'h4;
      @(posedge clk_sys);
      pc_load <= 1'b0;
      #1;
      `CHK("pc_out", 32'h0000_0400, pc_out)
      @(posedge clk_sys);
      pc_inc <= 1'b0;
      #1;
      `CHK("pc_out", 32'h0000_0404, pc_out)
      reg_read(PRF_REG_PC, 32'h0000_0404, 1'b0);
      // Data register operand sizes, quad wraps to the first register
      gpr_write(4'h2, PRF_SZ_LONG, 5'h0, 64'h0000_0000_1122_3344);
      gpr_write(4'h2, PRF_SZ_BYTE, 5'h0, 64'h0000_0000_FFFF_FFAB);
      gpr_read(4'h2, 32'h1122_33AB);
      gpr_write(4'h2, PRF_SZ_WORD, 5'h0, 64'h0000_0000_FFFF_BEEF);
      gpr_write(4'h2, PRF_SZ_BIT, 5'h14, 64'h0000_0000_0000_0001);
      gpr_read(4'h2, 32'h1132_BEEF);
      gpr_write(4'h7, PRF_SZ_QUAD, 5'h0, 64'h89AB_CDEF_0123_4567);
      gpr_read(4'h7, 32'h0123_4567);
      gpr_read(4'h0, 32'h89AB_CDEF);
      // Address registers: word sign-extends, byte refused
      gpr_write(4'h9, PRF_SZ_LONG, 5'h0, 64'h0000_0000_5555_5555);
      gpr_write(4'h9, PRF_SZ_WORD, 5'h0, 64'h0000_0000_0000_8001);
      gpr_write(4'h9, PRF_SZ_BYTE, 5'h0, 64'h0000_0000_0000_0012);
      gpr_read(4'h9, 32'hFFFF_8001);
      idx_read(4'h2, 1'b0, 32'hFFFF_BEEF);
      idx_read(4'h2, 1'b1, 32'h1132_BEEF);
      idx_read(4'h9, 1'b1, 32'hFFFF_8001);
      // Stack register seven follows privilege
      gpr_write(4'hF, PRF_SZ_LONG, 5'h0, 64'h0000_0000_0000_A000);
      reg_write(PRF_REG_USP, 32'h0000_B000);
      reg_read(PRF_REG_SSP, 32'h0000_A000, 1'b0);
      gpr_read(4'hF, 32'h0000_A000);
      reg_write(PRF_REG_SR, 32'h0000_8000);
      #1;
      `CHK("super_mode", 1'b0, super_mode)
      gpr_read(4'hF, 32'h0000_B000);
      gpr_write(4'hF, PRF_SZ_LONG, 5'h0, 64'h0000_0000_0000_B100);
      // User level: condition byte only
      reg_read(PRF_REG_SR, 32'h0, 1'b1);
      reg_write(PRF_REG_VBR, 32'h0000_FFFF);
      reg_write(PRF_REG_SR, 32'h0000_2700);
      #1;
      `CHK("reg_denied", 1'b1, reg_denied)
      `CHK("super_mode", 1'b0, super_mode)
      reg_write(PRF_REG_CCR, 32'h0000_000A);
      reg_read(PRF_REG_CCR, 32'h0000_000A, 1'b0);
      irq_chk(3'h1, 1'b1);
      irq_chk(3'h0, 1'b0);
      acc(1'b0, 1'b0, 1'b0, PRF_FC_UDATA);
      acc(1'b1, 1'b0, 1'b0, PRF_FC_UPROG);
      // Interrupt exception entry restores supervisor state
      @(posedge clk_sys);
      exc_enter <= 1'b1;
      exc_irq   <= 1'b1;
      irq_level <= 3'h5;
      @(posedge clk_sys);
      exc_enter <= 1'b0;
      exc_irq   <= 1'b0;
      #1;
      `CHK("sr_out", 16'h250A, sr_out)
      `CHK("trace_on", 1'b0, trace_on)
      reg_read(PRF_REG_VBR, 32'h0000_1000, 1'b0);
      reg_read(PRF_REG_USP, 32'h0000_B100, 1'b0);
      final_report();
   end
endmodule : tb_processor_register_file
